// File: logic/bar_gauge_regs.vh
`ifndef BAR_GAUGE_REGS_VH
`define BAR_GAUGE_REGS_VH

`define CLK_HZ            10000000
`define DISPLAY_REQUEST_INPUT_TIME_MS      4000
`define DISPLAY_REQUEST_INPUT_CYCLES       ((`CLK_HZ / 1000) * `DISPLAY_REQUEST_INPUT_TIME_MS)
`define BLINK_TIME_MS     250
`define BLINK_CYCLES      ((`CLK_HZ / 1000) * `BLINK_TIME_MS)

`define WB_ADR_CTRL       8'h00
`define WB_ADR_SOC        8'h04
`define WB_ADR_CAP        8'h08
`define WB_ADR_STAT       8'h0C

`define CTRL_ABS_BIT      0
`define CTRL_CNT_LSB      1
`define CTRL_EOD_BIT      3
`define CTRL_RESET        4'h0

`define SEG_CNT_FIVE      2'h0
`define SEG_CNT_FOUR      2'h1
`define SEG_CNT_THREE     2'h2

`endif

// File: logic/led_bar_gauge_display.v
// Chosen here: register access over Wishbone and the register addresses.
`include "bar_gauge_regs.vh"
`default_nettype none

module led_bar_gauge_display #(
  parameter [31:0] DISPLAY_REQUEST_INPUT_CYCLES  = `DISPLAY_REQUEST_INPUT_CYCLES,
  parameter [31:0] BLINK_CYCLES = `BLINK_CYCLES
) (
  input  wire        SYS_CLK,
  input  wire        RST,
  input  wire        CE,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        DISPLAY_REQUEST_INPUT,
  output reg         BAR_SEGMENT_ONE,
  output reg         BAR_SEGMENT_TWO,
  output reg         BAR_SEGMENT_THREE,
  output reg         BAR_SEGMENT_FOUR,
  output reg         BAR_SEGMENT_FIVE
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  reg  [3:0]  ctrl_q;
  reg  [6:0]  rel_soc_q;
  reg  [6:0]  abs_soc_q;
  reg  [15:0] rem_cap_q;
  reg  [15:0] alarm_cap_q;
  reg         req_meta_q;
  reg         req_sync_q;
  reg         req_prev_q;
  reg  [31:0] timer_q;
  reg  [31:0] blink_cnt_q;
  reg         blink_q;
  reg  [31:0] rd_d;

  wire        wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire        wb_wr    = wb_req & WB_WE_I;
  wire        running  = (timer_q != 32'h0000_0000);
  wire        abs_mode = ctrl_q[`CTRL_ABS_BIT];
  wire [1:0]  seg_cnt  = ctrl_q[`CTRL_CNT_LSB+1:`CTRL_CNT_LSB];
  wire        end_dsg  = ctrl_q[`CTRL_EOD_BIT];
  wire        fall     = req_prev_q & ~req_sync_q;
  wire        low_cap  = rem_cap_q < alarm_cap_q;

  // Merges write data into a register under the byte enables.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Number of lit segments for a charge level and segment option.
  function [2:0] lit_count;
    input [6:0] soc;
    input [1:0] cnt;
    begin
      case (cnt)
        `SEG_CNT_FOUR: begin
          if (soc >= 7'd75) lit_count = 3'd4;
          else if (soc >= 7'd50) lit_count = 3'd3;
          else if (soc >= 7'd25) lit_count = 3'd2;
          else lit_count = 3'd1;
        end
        `SEG_CNT_THREE: begin
          if (soc >= 7'd67) lit_count = 3'd3;
          else if (soc >= 7'd34) lit_count = 3'd2;
          else lit_count = 3'd1;
        end
        default: begin
          if (soc >= 7'd80) lit_count = 3'd5;
          else if (soc >= 7'd60) lit_count = 3'd4;
          else if (soc >= 7'd40) lit_count = 3'd3;
          else if (soc >= 7'd20) lit_count = 3'd2;
          else lit_count = 3'd1;
        end
      endcase
    end
  endfunction

  // Control word after a write, cut back to the four implemented bits.
  wire [31:0] ctrl_wr  = merge({28'h0000000, ctrl_q}, WB_DAT_I, WB_SEL_I);

  always @* begin
    case (WB_ADR_I)
      `WB_ADR_CTRL: rd_d = {28'h0000000, ctrl_q};
      `WB_ADR_SOC:  rd_d = {9'h000, abs_soc_q, 9'h000, rel_soc_q};
      `WB_ADR_CAP:  rd_d = {alarm_cap_q, rem_cap_q};
      `WB_ADR_STAT: rd_d = {29'h00000000, low_cap, blink_q, running};
      default:      rd_d = 32'h0000_0000;
    endcase
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      WB_ACK_O    <= 1'b0;
      WB_DAT_O    <= 32'h0000_0000;
      ctrl_q      <= `CTRL_RESET;
      rel_soc_q   <= 7'h00;
      abs_soc_q   <= 7'h00;
      rem_cap_q   <= 16'h0000;
      alarm_cap_q <= 16'h0000;
    end else if (CE) begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? rd_d : WB_DAT_O;
      if (wb_wr) begin
        case (WB_ADR_I)
          `WB_ADR_CTRL: begin
            ctrl_q <= ctrl_wr[3:0];
          end
          `WB_ADR_SOC: begin
            if (WB_SEL_I[0]) rel_soc_q <= WB_DAT_I[6:0];
            if (WB_SEL_I[2]) abs_soc_q <= WB_DAT_I[22:16];
          end
          `WB_ADR_CAP: begin
            {alarm_cap_q, rem_cap_q} <=
              merge({alarm_cap_q, rem_cap_q}, WB_DAT_I, WB_SEL_I);
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request edge detection and display timer.

  always @(posedge SYS_CLK) begin
    if (RST) begin
      req_meta_q <= 1'b1;
      req_sync_q <= 1'b1;
      req_prev_q <= 1'b1;
      timer_q    <= 32'h0000_0000;
    end else if (CE) begin
      req_meta_q <= DISPLAY_REQUEST_INPUT;
      req_sync_q <= req_meta_q;
      req_prev_q <= req_sync_q;
      if (running) begin
        timer_q <= timer_q - 32'h0000_0001;
      end else if (fall) begin
        timer_q <= DISPLAY_REQUEST_INPUT_CYCLES;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink and segment drive.

  reg [2:0] lit;
  reg [4:0] seg_d;

  always @* begin
    lit = lit_count(abs_mode ? abs_soc_q : rel_soc_q, seg_cnt);
    seg_d = 5'h00;
    if (running && !end_dsg && !(low_cap && blink_q)) begin
      seg_d = (5'h01 << lit) - 5'h01;
    end
  end

  always @(posedge SYS_CLK) begin
    if (RST) begin
      blink_cnt_q       <= 32'h0000_0000;
      blink_q           <= 1'b0;
      BAR_SEGMENT_ONE   <= 1'b0;
      BAR_SEGMENT_TWO   <= 1'b0;
      BAR_SEGMENT_THREE <= 1'b0;
      BAR_SEGMENT_FOUR  <= 1'b0;
      BAR_SEGMENT_FIVE  <= 1'b0;
    end else if (CE) begin
      if (!running || blink_cnt_q >= BLINK_CYCLES - 32'h0000_0001) begin
        blink_cnt_q <= 32'h0000_0000;
        blink_q     <= running ? ~blink_q : 1'b0;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
      end
      BAR_SEGMENT_ONE   <= seg_d[0];
      BAR_SEGMENT_TWO   <= seg_d[1];
      BAR_SEGMENT_THREE <= seg_d[2];
      BAR_SEGMENT_FOUR  <= seg_d[3];
      BAR_SEGMENT_FIVE  <= seg_d[4];
    end
  end

endmodule

`default_nettype wire

// File: verification/bar_gauge_checker.sv
`default_nettype none
module bar_gauge_checker (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic BAR_SEGMENT_ONE,
  input wire logic BAR_SEGMENT_TWO,
  input wire logic BAR_SEGMENT_THREE,
  input wire logic BAR_SEGMENT_FOUR,
  input wire logic BAR_SEGMENT_FIVE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST || !CE);
  a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  a_ack_cause: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("ack without request");
  a_rst_dark: assert property (disable iff (!CE) RST |=> !BAR_SEGMENT_ONE)
    else $error("segment lit after reset");
  a_five_four: assert property (BAR_SEGMENT_FIVE |-> BAR_SEGMENT_FOUR)
    else $error("segment five without four");
  a_four_three: assert property (BAR_SEGMENT_FOUR |-> BAR_SEGMENT_THREE)
    else $error("segment four without three");
  a_three_two: assert property (BAR_SEGMENT_THREE |-> BAR_SEGMENT_TWO)
    else $error("segment three without two");
  a_two_one: assert property (BAR_SEGMENT_TWO |-> BAR_SEGMENT_ONE)
    else $error("segment two without one");
endmodule
`default_nettype wire

// File: verification/led_bar_gauge_display_tb.sv
`default_nettype none
module led_bar_gauge_display_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic             SYS_CLK = 0, RST = 1, req = 0, we = 0, press = 0;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      dat = 32'h0, rv, n = 32'h0;
  wire logic        line, ack;
  wire logic [31:0] rdat;
  wire logic [4:0]  seg;
  int               error_cnt = 0, checked = 0;
  logic [35:0] tab [14] = '{36'h0_000013_01, 36'h0_000014_03, 36'h0_00004F_0F,
    36'h0_000050_1F, 36'h2_000018_01, 36'h2_000019_03, 36'h2_00004A_07,
    36'h2_00004B_0F, 36'h4_000021_01, 36'h4_000022_03, 36'h4_000043_07,
    36'h1_280000_07, 36'h0_280000_01, 36'h8_000050_00};
  always #50 SYS_CLK = ~SYS_CLK;
  push_button push_button_i (.press(press), .line(line));
  led_bar_gauge_display #(.DISPLAY_REQUEST_INPUT_CYCLES(32'hC8), .BLINK_CYCLES(32'hA))
    led_bar_gauge_display_i (.SYS_CLK(SYS_CLK), .RST(RST), .CE(1'b1),
    .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .DISPLAY_REQUEST_INPUT(line), .BAR_SEGMENT_ONE(seg[0]),
    .BAR_SEGMENT_TWO(seg[1]), .BAR_SEGMENT_THREE(seg[2]),
    .BAR_SEGMENT_FOUR(seg[3]), .BAR_SEGMENT_FIVE(seg[4]));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge SYS_CLK); while (ack !== 1'b1);
    rv = rdat;
    req <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    wb(0, 8'h00, 32'h0);
    chk("ctrl reset", rv, 32'h0);
    wb(1, 8'h10, 32'hFFFFFFFF);
    wb(0, 8'h10, 32'h0);
    chk("unmapped read", rv, 32'h0);
    $display("register test done");
    wb(1, 8'h08, 32'h00000064);
    foreach (tab[i]) begin
      wb(1, 8'h00, {28'h0, tab[i][35:32]});
      wb(1, 8'h04, {8'h0, tab[i][31:8]});
      press <= 1'b1;
      repeat (6) @(posedge SYS_CLK);
      chk("segments lit", {27'h0, seg}, {24'h0, tab[i][7:0]});
      press <= 1'b0;
      repeat (100) @(posedge SYS_CLK);
      chk("segments held", {27'h0, seg}, {24'h0, tab[i][7:0]});
      // A second press while the timer runs must not extend the display.
      press <= 1'b1;
      repeat (120) @(posedge SYS_CLK);
      chk("segments off", {27'h0, seg}, 32'h0);
      press <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
    end
    $display("table test done");
    wb(1, 8'h08, 32'h00640010);
    wb(1, 8'h00, 32'h0);
    wb(1, 8'h04, 32'h50);
    press <= 1'b1;
    repeat (6) @(posedge SYS_CLK);
    repeat (40) begin
      @(posedge SYS_CLK);
      n = n + (seg == 5'h1F);
    end
    chk("blink lit cycles", n, 32'h14);
    $display("blink test done");
    stop_test;
  end
  initial begin
    repeat (8000) @(posedge SYS_CLK);
    error_cnt++;
    stop_test;
  end
endmodule
bind led_bar_gauge_display bar_gauge_checker bar_gauge_checker_i (
  .SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
  .BAR_SEGMENT_ONE(BAR_SEGMENT_ONE), .BAR_SEGMENT_TWO(BAR_SEGMENT_TWO),
  .BAR_SEGMENT_THREE(BAR_SEGMENT_THREE), .BAR_SEGMENT_FOUR(BAR_SEGMENT_FOUR),
  .BAR_SEGMENT_FIVE(BAR_SEGMENT_FIVE));
`default_nettype wire

// File: verification/push_button.sv
`default_nettype none
module push_button (
  input  wire logic press,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ns;
  // The pull-up holds the line high whenever the switch is open.
  assign line = !press;
endmodule
`default_nettype wire
